// *** verilog/ioexp_slave.sv ***
// Purpose: I2C slave of a 16-bit port expander with change alert
// Assumes: SCL and SDA are oversampled by the 50 MHz clock
// Notes: Open-drain pins appear as level, drive value and enable

`timescale 1ns/1ps

// How it works
// - Input pin edge asserts the alert
// - Alert drops on pin return or port read
// - Read clears alert at ACK SCL rise
// - Change during ACK pulse may vanish
// - Changes after clearing raise alert again
// - Output pins never raise the alert
// - Output-to-input switch may give false alert
// - Command loads pointer; data hits selected register
// - Pointer toggles within pair after each data byte
// - Unlimited write bytes, other registers untouched
// - Transmit byte captured at ACK falling edge
// - Read selected first, then alternate, unlimited
// - Pointer keeps alternation across a restart
// - STOP anytime; data and pointer stay valid
// - Reset restores registers and bus machine
// - Low three pointer bits pick one register
// - Direction 1 is input, reset all ones
// - Polarity bit inverts reported input level
// - Input register writes ignored, pointer advances
module ioexp_slave
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // I2C bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  // Address straps
  input wire logic i_addr_strap_0,
  input wire logic i_addr_strap_1,
  input wire logic i_addr_strap_2,
  // Port pins
  input wire logic [15:0] i_port,
  output logic [15:0] o_port,
  output logic [15:0] o_port_oe_n,
  // Change alert, open drain
  input wire logic i_alert,
  output logic o_alert,
  output logic o_alert_oe_n
);
  import ioexp_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  ioexp_regs_t r_reg;   // Registered state
  ioexp_regs_t r_next;  // Next state

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  // Input registers show live pins through the polarity mask
  function automatic logic [7:0] rd_byte(input ioexp_regs_t s, input logic [2:0] idx);
    logic [15:0] inv;
    inv = s.port_s2 ^ s.pol_reg;
    case (idx)
      IOEXP_REG_IN0: rd_byte = inv[7:0];
      IOEXP_REG_IN1: rd_byte = inv[15:8];
      IOEXP_REG_OUT0: rd_byte = s.out_reg[7:0];
      IOEXP_REG_OUT1: rd_byte = s.out_reg[15:8];
      IOEXP_REG_POL0: rd_byte = s.pol_reg[7:0];
      IOEXP_REG_POL1: rd_byte = s.pol_reg[15:8];
      IOEXP_REG_CFG0: rd_byte = s.cfg_reg[7:0];
      default: rd_byte = s.cfg_reg[15:8];
    endcase
  endfunction : rd_byte

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Bus events are found from synchronised levels only
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic addr_hit;
    logic [15:0] changed;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_cond = 1'b0;
    stop_cond = 1'b0;
    addr_hit = 1'b0;
    changed = 16'h0000;
    r_next = r_reg;

    // Synchronisers: stage 1 feeds stage 2 only
    r_next.scl_s1 = i_scl;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d = r_reg.scl_s2;
    r_next.sda_s1 = i_sda;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d = r_reg.sda_s2;
    r_next.port_s1 = i_port;
    r_next.port_s2 = r_reg.port_s1;
    r_next.strap_s1 = {i_addr_strap_2, i_addr_strap_1, i_addr_strap_0};
    r_next.strap_s2 = r_reg.strap_s1;
    r_next.drive_lo = 1'b0;

    // Edge and condition detection on stage 2 and its delay
    scl_rise = r_reg.scl_s2 & ~r_reg.scl_d;
    scl_fall = ~r_reg.scl_s2 & r_reg.scl_d;
    start_cond = r_reg.scl_s2 & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s2;
    stop_cond = r_reg.scl_s2 & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s2;
    addr_hit = (r_reg.shift[7:1] == {IOEXP_ADDR_HI, r_reg.strap_s2});

    // Bus machine; start and stop override any state
    if (start_cond)
    begin
      // Also a restart; pointer is left as it stands
      r_next.state = ST_RX;
      r_next.phase = PH_ADDR;
      r_next.bitcnt = 4'h0;
      r_next.sda_oe_n = 1'b1;
    end
    else if (stop_cond)
    begin
      // Pointer and registers stay as they are
      r_next.state = ST_IDLE;
      r_next.sda_oe_n = 1'b1;
    end
    else
    begin
      case (r_reg.state)
        ST_IDLE:
        begin
          // Wait for a start; bus idle is the master's concern
          r_next.sda_oe_n = 1'b1;
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            // Sample data while SCL is high
            r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          else if (scl_fall && r_reg.bitcnt == IOEXP_BITS_PER_BYTE)
          begin
            r_next.state = ST_ACK;
            r_next.sda_oe_n = 1'b0;
            case (r_reg.phase)
              PH_ADDR:
              begin
                // Direction bit picks write or read
                r_next.rw = r_reg.shift[0];
                if (!addr_hit)
                begin
                  // Not ours: stay off the bus
                  r_next.state = ST_IDLE;
                  r_next.sda_oe_n = 1'b1;
                end
              end
              PH_CMD:
              begin
                r_next.ptr = r_reg.shift;
              end
              default:
              begin
                // Store into the selected register only
                case (r_reg.ptr[2:0])
                  IOEXP_REG_OUT0: r_next.out_reg[7:0] = r_reg.shift;
                  IOEXP_REG_OUT1: r_next.out_reg[15:8] = r_reg.shift;
                  IOEXP_REG_POL0: r_next.pol_reg[7:0] = r_reg.shift;
                  IOEXP_REG_POL1: r_next.pol_reg[15:8] = r_reg.shift;
                  IOEXP_REG_CFG0: r_next.cfg_reg[7:0] = r_reg.shift;
                  IOEXP_REG_CFG1: r_next.cfg_reg[15:8] = r_reg.shift;
                  default: r_next.ptr = r_reg.ptr;  // Input regs ignore writes
                endcase
                // Toggle within the pair, input pair too
                r_next.ptr[0] = ~r_reg.ptr[0];
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            r_next.bitcnt = 4'h0;
            if (r_reg.phase == PH_ADDR && r_reg.rw)
            begin
              // Capture first byte at the ACK falling edge
              r_next.state = ST_TX;
              r_next.tx_reg = r_reg.ptr[2:0];
              r_next.shift = rd_byte(r_reg, r_reg.ptr[2:0]);
              r_next.sda_oe_n = r_next.shift[7];
              r_next.ptr[0] = ~r_reg.ptr[0];
            end
            else
            begin
              r_next.state = ST_RX;
              r_next.sda_oe_n = 1'b1;
              if (r_reg.phase == PH_ADDR)
              begin
                r_next.phase = PH_CMD;
              end
              else
              begin
                r_next.phase = PH_DATA;
              end
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise)
          begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (r_reg.bitcnt == IOEXP_BITS_PER_BYTE)
            begin
              // Release SDA for the master's acknowledge
              r_next.state = ST_MACK;
              r_next.sda_oe_n = 1'b1;
            end
            else
            begin
              r_next.shift = {r_reg.shift[6:0], 1'b0};
              r_next.sda_oe_n = r_reg.shift[6];
            end
          end
        end
        ST_MACK:
        begin
          if (scl_rise)
          begin
            r_next.macked = ~r_reg.sda_s2;
            // Clear alert of the port just read
            // A pin change in this very cycle is absorbed
            if (r_reg.tx_reg == IOEXP_REG_IN0)
            begin
              r_next.snap[7:0] = r_reg.port_s2[7:0];
            end
            else if (r_reg.tx_reg == IOEXP_REG_IN1)
            begin
              r_next.snap[15:8] = r_reg.port_s2[15:8];
            end
          end
          else if (scl_fall)
          begin
            r_next.bitcnt = 4'h0;
            if (r_reg.macked)
            begin
              // Next byte from the other register of the pair
              r_next.state = ST_TX;
              r_next.tx_reg = r_reg.ptr[2:0];
              r_next.shift = rd_byte(r_reg, r_reg.ptr[2:0]);
              r_next.sda_oe_n = r_next.shift[7];
              r_next.ptr[0] = ~r_reg.ptr[0];
            end
            else
            begin
              // NACK ends the read
              r_next.state = ST_IDLE;
              r_next.sda_oe_n = 1'b1;
            end
          end
        end
        default:
        begin
          r_next.state = ST_IDLE;
          r_next.sda_oe_n = 1'b1;
        end
      endcase
    end

    // Change alert; snapshot is taken once the pin synchronisers hold data
    if (r_reg.warm != IOEXP_WARM_DONE)
    begin
      r_next.warm = r_reg.warm + 2'h1;
      r_next.snap = r_reg.port_s2;
      r_next.alert_oe_n = 1'b1;
    end
    else
    begin
      // Only pins set as inputs count
      // Comparing with the stored value means a pin that returns releases
      // the line, a re-armed pin alerts again, and a pin turned into an
      // input with a different level alerts at once
      changed = (r_reg.port_s2 ^ r_reg.snap) & r_reg.cfg_reg;
      r_next.alert_oe_n = ~(|changed);
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Synchronous reset puts every field to its default
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r_reg <= '0;
      r_reg.scl_s1 <= 1'b1;
      r_reg.scl_s2 <= 1'b1;
      r_reg.scl_d <= 1'b1;
      r_reg.sda_s1 <= 1'b1;
      r_reg.sda_s2 <= 1'b1;
      r_reg.sda_d <= 1'b1;
      r_reg.state <= ST_IDLE;
      r_reg.phase <= PH_ADDR;
      r_reg.ptr <= IOEXP_PTR_RST;
      r_reg.out_reg <= IOEXP_OUT_RST;
      r_reg.pol_reg <= IOEXP_POL_RST;
      r_reg.cfg_reg <= IOEXP_CFG_RST;
      r_reg.sda_oe_n <= 1'b1;
      r_reg.alert_oe_n <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  assign o_sda = r_reg.drive_lo;
  assign o_sda_oe_n = r_reg.sda_oe_n;
  assign o_port = r_reg.out_reg;
  assign o_port_oe_n = r_reg.cfg_reg;  // Direction 1 floats the pin
  assign o_alert = r_reg.drive_lo;
  assign o_alert_oe_n = r_reg.alert_oe_n;

endmodule : ioexp_slave

// *** inc/ioexp_pkg.sv ***
// Purpose: Shared constants and types for the I2C port expander slave
// Assumes: 50 MHz system clock, bus lines sampled and synchronised
// Notes: All state of the slave travels in one packed struct

package ioexp_pkg;

  // ----------------------------------------
  // Register indices (low three pointer bits)
  // ----------------------------------------
  localparam logic [2:0] IOEXP_REG_IN0 = 3'h0;   // Input port 0, read only
  localparam logic [2:0] IOEXP_REG_IN1 = 3'h1;   // Input port 1, read only
  localparam logic [2:0] IOEXP_REG_OUT0 = 3'h2;  // Output port 0
  localparam logic [2:0] IOEXP_REG_OUT1 = 3'h3;  // Output port 1
  localparam logic [2:0] IOEXP_REG_POL0 = 3'h4;  // Polarity inversion 0
  localparam logic [2:0] IOEXP_REG_POL1 = 3'h5;  // Polarity inversion 1
  localparam logic [2:0] IOEXP_REG_CFG0 = 3'h6;  // Direction 0
  localparam logic [2:0] IOEXP_REG_CFG1 = 3'h7;  // Direction 1

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [15:0] IOEXP_OUT_RST = 16'hFFFF;  // Outputs high
  localparam logic [15:0] IOEXP_POL_RST = 16'h0000;  // No inversion
  localparam logic [15:0] IOEXP_CFG_RST = 16'hFFFF;  // All pins inputs
  localparam logic [7:0] IOEXP_PTR_RST = 8'h00;      // Points at input port 0

  // ----------------------------------------
  // Bus framing and counts
  // ----------------------------------------
  localparam logic [3:0] IOEXP_BITS_PER_BYTE = 4'h8;  // Bits per byte
  localparam logic [1:0] IOEXP_WARM_DONE = 2'h3;      // Cycles to fill pin synchronisers
  // Fixed upper address nibble; value is arbitrary
  localparam logic [3:0] IOEXP_ADDR_HI = 4'h4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,  // Not addressed
    ST_RX = 5'h02,    // Shifting a byte in
    ST_ACK = 5'h04,   // Own acknowledge bit
    ST_TX = 5'h08,    // Shifting a byte out
    ST_MACK = 5'h10   // Master acknowledge bit
  } ioexp_state_t;

  typedef enum logic [1:0]
  {
    PH_ADDR = 2'h0,  // Expecting the address byte
    PH_CMD = 2'h1,   // Expecting the command byte
    PH_DATA = 2'h2   // Expecting data bytes
  } ioexp_phase_t;

  typedef struct packed
  {
    logic scl_s1;            // Synchroniser stage 1
    logic scl_s2;            // Synchroniser stage 2
    logic scl_d;             // Previous sampled level
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    logic [15:0] port_s1;    // Pin synchroniser stage 1
    logic [15:0] port_s2;    // Pin synchroniser stage 2
    logic [2:0] strap_s1;    // Strap synchroniser stage 1
    logic [2:0] strap_s2;    // Strap synchroniser stage 2
    ioexp_state_t state;     // Bus state
    ioexp_phase_t phase;     // Which byte is expected
    logic [3:0] bitcnt;      // Bits moved in this byte
    logic [7:0] shift;       // Shift register
    logic rw;                // Direction bit of the address
    logic macked;            // Master acknowledged last byte
    logic [7:0] ptr;         // Pointer register
    logic [2:0] tx_reg;      // Register now being sent
    logic [15:0] out_reg;    // Output latches
    logic [15:0] pol_reg;    // Polarity inversion
    logic [15:0] cfg_reg;    // Direction, 1 = input
    logic [15:0] snap;       // Pin levels as last read
    logic [1:0] warm;        // Start-up counter
    logic sda_oe_n;          // Low pulls SDA low
    logic alert_oe_n;        // Low pulls the alert line low
    logic drive_lo;          // Level driven on open-drain pins
  } ioexp_regs_t;

endpackage : ioexp_pkg

// *** testbench/ioexp_slave_asserts.sv ***
// Purpose: Pin timing checks on the port expander slave
// Assumes: Pins and bus never change in the same few cycles
// Notes: Bound to the slave, watches its ports only
`timescale 1ns/1ps
module ioexp_slave_asserts
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Watched pins
  input wire logic i_scl,
  input wire logic [15:0] i_port,
  input wire logic [15:0] o_port,
  input wire logic [15:0] o_port_oe_n,
  input wire logic o_sda,
  input wire logic o_sda_oe_n,
  input wire logic o_alert,
  input wire logic o_alert_oe_n
);
  default clocking dcb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ------------------------------
  // Checks
  // ------------------------------
  chk_alert_level: assert property (o_alert == 1'h0)
    else $error("alert drive level not low");
  chk_sda_level: assert property (o_sda == 1'h0)
    else $error("data drive level not low");
  chk_reset_vals: assert property ($past(i_rst) |-> o_port == 16'hFFFF &&
    o_port_oe_n == 16'hFFFF && o_alert_oe_n && o_sda_oe_n)
    else $error("wrong output values after reset");
  // Quiet alert, then an input pin moves: must pull low
  chk_alert_edge: assert property (($stable(i_port) && o_alert_oe_n)[*4] ##1
    ($changed(i_port) && |((i_port ^ $past(i_port)) & o_port_oe_n) && i_scl) ##1
    ($stable(i_port) && $stable(o_port_oe_n))[*6] |-> !o_alert_oe_n)
    else $error("input pin change gave no alert");
  // Only driven pins move: alert stays released
  chk_out_quiet: assert property (($stable(i_port) && o_alert_oe_n)[*4] ##1
    ($changed(i_port) && !(|((i_port ^ $past(i_port)) & o_port_oe_n)) &&
    $stable(o_port_oe_n)) |-> o_alert_oe_n[*6])
    else $error("output pin change raised alert");
  // Registers land while the clock line is low
  chk_dir_on_low: assert property ($changed(o_port_oe_n) |-> !i_scl)
    else $error("direction changed with clock high");
  chk_port_on_low: assert property ($changed(o_port) |-> !i_scl && !$past(i_scl))
    else $error("output latch changed with clock high");
  chk_sda_on_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
    else $error("data line moved with clock high");
endmodule : ioexp_slave_asserts

bind ioexp_slave ioexp_slave_asserts ioexp_slave_asserts_i
(
  .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_port(i_port),
  .o_port(o_port), .o_port_oe_n(o_port_oe_n), .o_sda(o_sda),
  .o_sda_oe_n(o_sda_oe_n), .o_alert(o_alert), .o_alert_oe_n(o_alert_oe_n)
);

// *** testbench/ioexp_mst.sv ***
// Purpose: Behavioural bus master facing the expander
// Assumes: Called just after a system clock edge
// Notes: Bit is 120 ns low and 40 ns high, 160 ns in all
`timescale 1ns/1ps
module ioexp_mst
(
  // Wire level with pull-up
  input wire logic i_sda_wire,
  // Master drive, high means released
  output logic o_scl,
  output logic o_sda
);
  // Bus idle at start, clock stands still between frames
  initial
  begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  // Data moves only in the low phase, sampled mid high
  task automatic xbit(input logic b, output logic r);
    #60 o_sda = b;
    #60 o_scl = 1'h1;
    #20 r = i_sda_wire;
    #20 o_scl = 1'h0;
  endtask : xbit
  // Start from idle, or restart from mid-frame
  task automatic start();
    if (!o_scl)
    begin
      #60 o_sda = 1'h1;
      #60 o_scl = 1'h1;
    end
    #40 o_sda = 1'h0;
    #60 o_scl = 1'h0;
  endtask : start
  // Stop leaves both lines released
  task automatic stop();
    #60 o_sda = 1'h0;
    #60 o_scl = 1'h1;
    #40 o_sda = 1'h1;
    #100;
  endtask : stop
  // Byte out, MSB first, ack seen as low
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'h1, r);
    ack = !r;
  endtask : send
  // Byte in, last one not acknowledged
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      xbit(1'h1, r);
      d = {d[6:0], r};
    end
    xbit(last, r);
  endtask : recv
endmodule : ioexp_mst

// *** testbench/ioexp_slave_bench.sv ***
// Purpose: Self-checking bench of the expander slave
// Assumes: Straps at 5, pins follow the slave when driven
// Notes: Scenarios run in order and share register state
`timescale 1ns/1ps
module ioexp_slave_bench;
  import ioexp_pkg::*;
  logic i_clk, i_rst, scl, sda_m, sda_w, o_sda, o_sda_oe_n, o_alert, o_alert_oe_n, ack;
  logic [15:0] ext, pins, o_port, o_port_oe_n;
  logic [7:0] rd;
  int errors, n_tests;
  localparam logic [6:0] ADDR = {IOEXP_ADDR_HI, 3'h5};
  // Open-drain wire and pins that follow the slave where driven
  assign sda_w = sda_m & (o_sda_oe_n | o_sda);
  assign pins = (o_port_oe_n & ext) | (~o_port_oe_n & o_port);
  ioexp_mst ioexp_mst_i (.i_sda_wire(sda_w), .o_scl(scl), .o_sda(sda_m));
  ioexp_slave ioexp_slave_i
  (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n), .i_addr_strap_0(1'h1), .i_addr_strap_1(1'h0),
    .i_addr_strap_2(1'h1), .i_port(pins), .o_port(o_port), .o_port_oe_n(o_port_oe_n),
    .i_alert(o_alert_oe_n | o_alert), .o_alert(o_alert), .o_alert_oe_n(o_alert_oe_n)
  );
  // ------------------------------
  // Helpers
  // ------------------------------
  initial
  begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : idle
  task automatic addr(input logic rw);
    ioexp_mst_i.start();
    ioexp_mst_i.send({ADDR, rw}, ack);
    check("address ack", 16'h1, {15'h0, ack});
  endtask : addr
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, d1, d2);
    addr(1'h0);
    ioexp_mst_i.send(cmd, ack);
    ioexp_mst_i.send(d0, ack);
    ioexp_mst_i.send(d1, ack);
    ioexp_mst_i.send(d2, ack);
    check("data ack", 16'h1, {15'h0, ack});
    ioexp_mst_i.stop();
    idle(4);
  endtask : wr
  task automatic rdb(input logic last, input logic [7:0] exp);
    ioexp_mst_i.recv(last, rd);
    check("read byte", {8'h0, exp}, {8'h0, rd});
  endtask : rdb
  task automatic flip(input int b, input logic exp_n);
    ext[b] = ~ext[b];
    idle(8);
    check("alert enable", {15'h0, exp_n}, {15'h0, o_alert_oe_n});
  endtask : flip
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset();
    check("port latch", 16'hFFFF, o_port);
    check("direction", 16'hFFFF, o_port_oe_n);
    check("released", 16'h3, {14'h0, o_alert_oe_n, o_sda_oe_n});
  endtask : t_reset
  task automatic t_write();
    wr(8'h03, 8'hAA, 8'h55, 8'h3C);
    check("pair write", 16'h3C55, o_port);
    check("others kept", 16'hFFFF, o_port_oe_n);
    wr(8'h01, 8'h00, 8'h00, 8'h00);
    check("input write ignored", 16'h3C55, o_port);
    addr(1'h1);
    rdb(1'h1, ext[7:0]);
    ioexp_mst_i.stop();
  endtask : t_write
  task automatic t_read();
    wr(8'h04, 8'h0F, 8'h00, 8'h0F);
    addr(1'h0);
    ioexp_mst_i.send(8'h01, ack);
    addr(1'h1);
    rdb(1'h0, 8'hA5);
    rdb(1'h0, 8'hCC);
    rdb(1'h1, 8'hA5);
    addr(1'h1);
    rdb(1'h1, 8'hCC);
    ioexp_mst_i.stop();
  endtask : t_read
  task automatic t_alert();
    flip(0, 1'h0);
    flip(0, 1'h1);
    flip(9, 1'h0);
    addr(1'h0);
    ioexp_mst_i.send(8'h01, ack);
    addr(1'h1);
    rdb(1'h1, 8'hA7);
    ioexp_mst_i.stop();
    idle(4);
    check("cleared by read", 16'h1, {15'h0, o_alert_oe_n});
    flip(9, 1'h0);
    addr(1'h1);
    rdb(1'h1, 8'hCC);
    ioexp_mst_i.stop();
    check("other port read", 16'h0, {15'h0, o_alert_oe_n});
    addr(1'h1);
    rdb(1'h1, 8'hA5);
    ioexp_mst_i.stop();
    check("own port read", 16'h1, {15'h0, o_alert_oe_n});
  endtask : t_alert
  task automatic t_outpin();
    wr(8'h06, 8'hFE, 8'hFF, 8'hFE);
    check("direction", 16'hFFFE, o_port_oe_n);
    wr(8'h02, 8'h54, 8'h3C, 8'h54);
    idle(8);
    check("output latch", 16'h3C54, o_port);
    check("no alert", 16'h1, {15'h0, o_alert_oe_n});
    ioexp_mst_i.start();
    ioexp_mst_i.send({IOEXP_ADDR_HI, 3'h2, 1'h0}, ack);
    check("foreign ack", 16'h0, {15'h0, ack});
    ioexp_mst_i.stop();
  endtask : t_outpin
  // Read back every writable pair through restarts
  task automatic t_readback();
    addr(1'h0);
    ioexp_mst_i.send(8'h02, ack);
    addr(1'h1);
    rdb(1'h0, 8'h54);
    rdb(1'h1, 8'h3C);
    addr(1'h0);
    ioexp_mst_i.send(8'h05, ack);
    addr(1'h1);
    rdb(1'h0, 8'h00);
    rdb(1'h1, 8'h0F);
    addr(1'h0);
    ioexp_mst_i.send(8'h07, ack);
    addr(1'h1);
    rdb(1'h0, 8'hFF);
    rdb(1'h1, 8'hFE);
    ioexp_mst_i.stop();
  endtask : t_readback
  // Port 0 read while pin 0 drives low, then pin 0 back to input
  task automatic t_false_alert();
    addr(1'h0);
    ioexp_mst_i.send(8'h00, ack);
    addr(1'h1);
    rdb(1'h1, 8'hCD);
    ioexp_mst_i.stop();
    wr(8'h06, 8'hFF, 8'hFF, 8'hFF);
    check("direction", 16'hFFFF, o_port_oe_n);
    check("false alert", 16'h0, {15'h0, o_alert_oe_n});
  endtask : t_false_alert
  // ------------------------------
  // Run and verdict
  // ------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial
  begin
    #400000;
    errors++;
    final_report();
  end
  initial
  begin
    errors = 0;
    n_tests = 0;
    ext = 16'hA5C3;
    i_rst = 1'h1;
    idle(3);
    i_rst = 1'h0;
    idle(12);
    t_reset();
    t_write();
    t_read();
    t_alert();
    t_outpin();
    t_readback();
    t_false_alert();
    final_report();
  end
endmodule : ioexp_slave_bench
